// ==== pkg/fis_consts.svh ====
// Offsets, field positions, reset values and timing counts for the flash status and tick block.
// Assumes it is included by its bare name from design files only.
`ifndef FIS_CONSTS_SVH
`define FIS_CONSTS_SVH
`define FIS_OFS_RAW_STATUS 12'h00C
`define FIS_OFS_IRQ_ENABLE 12'h010
`define FIS_OFS_MASKED_CLEAR 12'h014
`define FIS_OFS_TICK_RELOAD 12'h140
`define FIS_BIT_BAD_ACCESS 0
`define FIS_BIT_PROG_DONE 1
`define FIS_RST_TICK_RELOAD 8'h31
`define FIS_RST_IRQ_ENABLE 2'h0
`define FIS_RST_RAW_STATUS 2'h0
`define FIS_HV_PULSE_US 16'h0014
`define FIS_RESP_OKAY 2'h0
`define FIS_RESP_SLVERR 2'h2
`endif

// ==== pkg/fis_pkg.sv ====
// Types shared by the flash status and tick block.
// Assumes nothing of its surroundings.
package fis_pkg;
  typedef enum logic [1:0] {
    FIS_HV_IDLE = 2'b01,
    FIS_HV_ON = 2'b10
  } fis_hv_state_t;
  typedef logic [1:0] fis_evt_t;
endpackage

// ==== hdl/fis_tick.sv ====
// Microsecond tick divider and high-voltage pulse timer.
// Assumes start_i comes from logic on clk_i and reload_i is held stable during a pulse.
`timescale 1ns/10ps
`include "fis_consts.svh"
module fis_tick #(
  parameter logic [15:0] PULSE_US = `FIS_HV_PULSE_US
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] reload_i,
  input wire logic start_i,
  output logic tick_o,
  output logic hv_pulse_o,
  output logic done_o
);
  logic [7:0] cnt_reg;
  logic [15:0] us_reg;
  fis_pkg::fis_hv_state_t state_reg;
  logic start_ok;

  assign start_ok = start_i && (state_reg == fis_pkg::FIS_HV_IDLE);

  // A start realigns the divider so the pulse spans whole microseconds.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_reg <= `FIS_RST_TICK_RELOAD;
      tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      tick_o <= 1'b0;
      if (start_ok)
        cnt_reg <= reload_i;
      else if (cnt_reg == 8'h00)
      begin
        cnt_reg <= reload_i;
        tick_o <= 1'b1;
      end
      else
        cnt_reg <= cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= fis_pkg::FIS_HV_IDLE;
      us_reg <= 16'h0000;
      hv_pulse_o <= 1'b0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      case (state_reg)
        fis_pkg::FIS_HV_IDLE:
        begin
          if (start_i)
          begin
            state_reg <= fis_pkg::FIS_HV_ON;
            us_reg <= PULSE_US;
            hv_pulse_o <= 1'b1;
          end
        end
        fis_pkg::FIS_HV_ON:
        begin
          if (cnt_reg == 8'h00)
          begin
            if (us_reg == 16'h0001)
            begin
              state_reg <= fis_pkg::FIS_HV_IDLE;
              hv_pulse_o <= 1'b0;
              done_o <= 1'b1;
            end
            us_reg <= us_reg - 16'h0001;
          end
        end
        default:
        begin
          state_reg <= fis_pkg::FIS_HV_IDLE;
          hv_pulse_o <= 1'b0;
        end
      endcase
    end
  end

  logic [23:0] width_reg;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      width_reg <= 24'h00_0000;
    else if (ce_i)
      width_reg <= hv_pulse_o ? width_reg + 24'h00_0001 : 24'h00_0000;
  end

  sequence s_tick_seen;
    ce_i && tick_o;
  endsequence
  sequence s_quiet_period;
    cnt_reg == $past(reload_i);
  endsequence

  AST_TICK_RELOADS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_tick_seen |-> s_quiet_period)
    else $error("Divider did not reload after a tick.");
  AST_PULSE_WIDTH: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && done_o) |-> (width_reg == 24'(PULSE_US) * 24'({16'h0000, reload_i} + 24'h00_0001)))
    else $error("High-voltage pulse width is wrong.");
endmodule

// ==== hdl/fis_top.sv ====
// Flash controller interrupt status, interrupt enable and microsecond tick reload, on an AXI4-Lite slave.
// Assumes event inputs and the pulse start come from logic on clk_i; one clock, synchronous reset.
//
// Notes on behaviour
// - The masked programming flag, bit 1, is set when a program or erase cycle completes and its enable is one.
// - Writing one to masked bit 1 clears it and the raw programming flag; writing zero does nothing.
// - The masked access flag, bit 0, is set on an improper flash access while its enable is one.
// - Writing one to masked bit 0 clears it and the raw access flag; writing zero does nothing.
// - A microsecond tick comes every reload plus one clocks from a counter reloaded from the reload value.
// - The tick times the high-voltage pulse so it stays between its least and most duration.
// - The reload field resets to 0x31, the value for a 50 MHz clock.
// - Bits 31:8 of the reload register read as zero and software does not depend on them.
// - Raw flags are set on cycle completion and on a protection violation whatever the enables say.
// - A raw flag reaches the interrupt only while its enable bit is one; programming is bit 1, access bit 0.
`timescale 1ns/10ps
`include "fis_consts.svh"
module fis_top #(
  parameter int ADDR_W = 12,
  parameter logic [15:0] HV_PULSE_US = `FIS_HV_PULSE_US
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic hv_start_i,
  input wire logic bad_access_evt_i,
  output logic hv_pulse_o,
  output logic tick_reload_value_tick_o,
  output logic irq_o,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o
);
  logic [7:0] tick_reload_reg;
  logic [1:0] irq_enable_reg;
  fis_pkg::fis_evt_t raw_reg;
  fis_pkg::fis_evt_t raw_next;
  fis_pkg::fis_evt_t masked;
  fis_pkg::fis_evt_t evt;
  fis_pkg::fis_evt_t clr;
  logic prog_done;

  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_fire;
  logic w_fire;
  logic wr_do;
  logic ar_fire;
  logic aw_full_next;
  logic w_full_next;
  logic wr_reload;
  logic wr_enable;
  logic wr_clear;
  logic wr_hit;
  logic [31:0] rd_data;
  logic rd_hit;

  fis_tick #(
    .PULSE_US(HV_PULSE_US)
  ) u_tick (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .reload_i(tick_reload_reg),
    .start_i(hv_start_i),
    .tick_o(tick_reload_value_tick_o),
    .hv_pulse_o(hv_pulse_o),
    .done_o(prog_done)
  );

  // Write address and data are taken independently and held until both are present.
  assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire = s_axi_wvalid_i && s_axi_wready_o;
  assign wr_do = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;

  always_comb
  begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    if (aw_fire)
      aw_full_next = 1'b1;
    else if (wr_do)
      aw_full_next = 1'b0;
    if (w_fire)
      w_full_next = 1'b1;
    else if (wr_do)
      w_full_next = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else if (ce_i)
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      s_axi_awready_o <= !aw_full_next;
      s_axi_wready_o <= !w_full_next;
      if (aw_fire)
        awaddr_reg <= s_axi_awaddr_i;
      if (w_fire)
      begin
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
    end
  end

  assign wr_reload = wr_do && (awaddr_reg == ADDR_W'(`FIS_OFS_TICK_RELOAD));
  assign wr_enable = wr_do && (awaddr_reg == ADDR_W'(`FIS_OFS_IRQ_ENABLE));
  assign wr_clear = wr_do && (awaddr_reg == ADDR_W'(`FIS_OFS_MASKED_CLEAR));
  assign wr_hit = wr_reload || wr_enable || wr_clear || (awaddr_reg == ADDR_W'(`FIS_OFS_RAW_STATUS));

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `FIS_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (wr_do)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? `FIS_RESP_OKAY : `FIS_RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tick_reload_reg <= `FIS_RST_TICK_RELOAD;
    else if (ce_i && wr_reload && wstrb_reg[0])
      tick_reload_reg <= wdata_reg[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      irq_enable_reg <= `FIS_RST_IRQ_ENABLE;
    else if (ce_i && wr_enable && wstrb_reg[0])
      irq_enable_reg <= wdata_reg[1:0];
  end

  // Raw flags record every event seen while ce_i is high; a new event in the clearing cycle wins over the clear.
  assign evt[`FIS_BIT_PROG_DONE] = prog_done;
  assign evt[`FIS_BIT_BAD_ACCESS] = bad_access_evt_i;
  assign clr = (wr_clear && wstrb_reg[0]) ? wdata_reg[1:0] : 2'h0;
  assign raw_next = (raw_reg & ~clr) | evt;
  assign masked = raw_reg & irq_enable_reg;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      raw_reg <= `FIS_RST_RAW_STATUS;
    else if (ce_i)
      raw_reg <= raw_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      irq_o <= 1'b0;
    else if (ce_i)
      irq_o <= |masked;
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr_i)
      ADDR_W'(`FIS_OFS_RAW_STATUS): rd_data[1:0] = raw_reg;
      ADDR_W'(`FIS_OFS_IRQ_ENABLE): rd_data[1:0] = irq_enable_reg;
      ADDR_W'(`FIS_OFS_MASKED_CLEAR): rd_data[1:0] = masked;
      ADDR_W'(`FIS_OFS_TICK_RELOAD): rd_data[7:0] = tick_reload_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `FIS_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (ar_fire)
      begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_data;
        s_axi_rresp_o <= rd_hit ? `FIS_RESP_OKAY : `FIS_RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
      else if (!s_axi_rvalid_o)
        s_axi_arready_o <= 1'b1;
    end
  end

  logic rd_reload_reg;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rd_reload_reg <= 1'b0;
    else if (ce_i && ar_fire)
      rd_reload_reg <= (s_axi_araddr_i == ADDR_W'(`FIS_OFS_TICK_RELOAD));
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_prog_event;
    ce_i && prog_done;
  endsequence
  sequence s_access_event;
    ce_i && bad_access_evt_i;
  endsequence
  sequence s_clear_write(int b);
    ce_i && wr_clear && wstrb_reg[0] && wdata_reg[b];
  endsequence

  AST_PROG_MASKED_SET: assert property (
    s_prog_event ##0 irq_enable_reg[1] ##1 ce_i |-> masked[1] ##1 (!ce_i || irq_o))
    else $error("Programming completion did not raise the masked flag and interrupt.");
  AST_PROG_CLEAR: assert property (
    s_clear_write(1) ##0 !prog_done |=> !raw_reg[1] && !masked[1])
    else $error("Write of one did not clear the programming flags.");
  AST_ACCESS_MASKED_SET: assert property (
    s_access_event ##0 irq_enable_reg[0] |=> masked[0])
    else $error("Improper access did not raise the masked flag.");
  AST_ACCESS_CLEAR: assert property (
    s_clear_write(0) ##0 !bad_access_evt_i |=> !raw_reg[0])
    else $error("Write of one did not clear the access flags.");
  AST_ZERO_KEEPS: assert property (
    ce_i && wr_clear && !wdata_reg[0] && raw_reg[0] |=> raw_reg[0])
    else $error("Write of zero changed the access flag.");
  AST_RELOAD_RESET: assert property (@(posedge clk_i)
    $past(sys_rst_i) |-> tick_reload_reg == `FIS_RST_TICK_RELOAD)
    else $error("Tick reload did not reset to its default.");
  AST_RELOAD_UPPER_ZERO: assert property (
    s_axi_rvalid_o && rd_reload_reg |-> s_axi_rdata_o[31:8] == 24'h00_0000)
    else $error("Upper reload bits did not read as zero.");
  AST_RAW_UNMASKED: assert property (
    s_prog_event ##0 !irq_enable_reg[1] |=> raw_reg[1] && !masked[1])
    else $error("Masked-off event was not kept in the raw flag.");
  AST_IRQ_OR: assert property (
    ce_i |=> irq_o == $past(|(raw_reg & irq_enable_reg)))
    else $error("Interrupt is not the OR of the masked flags.");
  AST_WRITE_RESP: assert property (
    ce_i && wr_do ##1 ce_i |-> s_axi_bvalid_o)
    else $error("Write response missing.");
  AST_PROG_ZERO_KEEPS: assert property (
    ce_i && wr_clear && !wdata_reg[1] && raw_reg[1] |=> raw_reg[1])
    else $error("Write of zero changed the programming flag.");
  AST_ACCESS_RAW_UNMASKED: assert property (
    s_access_event ##0 !irq_enable_reg[0] |=> raw_reg[0] && !masked[0])
    else $error("Masked-off access was not kept in the raw flag.");
  AST_READ_ANSWER: assert property (
    ce_i && ar_fire |=> s_axi_rvalid_o)
    else $error("Read data did not follow the read address.");
  AST_RESET_CLEARS: assert property (@(posedge clk_i)
    $past(sys_rst_i) |-> raw_reg == `FIS_RST_RAW_STATUS && !irq_o && !s_axi_bvalid_o)
    else $error("Flags or interrupt did not reset.");

  // A low clock enable must leave every register as it was.
  AST_CE_FREEZE: assert property (
    !ce_i |=> $stable(raw_reg) && $stable(irq_enable_reg) && $stable(tick_reload_reg) && $stable(irq_o))
    else $error("State changed while the clock enable was low.");
endmodule

// ==== tb/flash_irq_status_tick_reload_value_tick_tb.sv ====
// Self-checking bench for the flash status, interrupt and microsecond tick block.
// Assumes the block answers on AXI4-Lite at 100 MHz with one synchronous reset.
`timescale 1ns/10ps
module flash_irq_status_tick_reload_value_tick_tb;
  localparam logic [15:0] PULSE = 16'h0002;
  localparam logic [11:0] A_RAW = 12'h00C;
  localparam logic [11:0] A_EN = 12'h010;
  localparam logic [11:0] A_MSK = 12'h014;
  localparam logic [11:0] A_RL = 12'h140;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hv_start = 1'b0;
  logic ce = 1'b1;
  logic bad_evt = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, hv_pulse, tick, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 33;
  int m_reload = 32'h0000_0031;
  int m_en = 0;
  int m_raw = 0;

  always #5 clk_i = ~clk_i;

  fis_top #(.ADDR_W(12), .HV_PULSE_US(PULSE)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .hv_start_i(hv_start),
    .bad_access_evt_i(bad_evt), .hv_pulse_o(hv_pulse), .tick_reload_value_tick_o(tick), .irq_o(irq),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("FAIL %0t timeout", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string what);
    num_checks++;
    if (act !== exp)
    begin
      errors++;
      $display("FAIL %0t %s got %h expected %h", $time, what, act, exp);
    end
  endtask

  function automatic logic [31:0] m_rd(input logic [11:0] a);
    case (a)
      A_RAW: return 32'(m_raw);
      A_EN: return 32'(m_en);
      A_MSK: return 32'(m_raw & m_en);
      A_RL: return 32'(m_reload);
      default: return 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [1:0] m_resp(input logic [11:0] a);
    return (a == A_RAW || a == A_EN || a == A_MSK || a == A_RL) ? 2'h0 : 2'h2;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_i);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    bready <= 1'b0;
    chk(32'(bresp), 32'(m_resp(a)), "bresp");
    case (a)
      A_EN: m_en = int'(d[1:0]);
      A_MSK: m_raw = m_raw & ~int'(d[1:0]);
      A_RL: m_reload = int'(d[7:0]);
      default: m_en = m_en;
    endcase
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, m_rd(a), "rdata");
    chk(32'(rresp), 32'(m_resp(a)), "rresp");
    @(posedge clk_i);
  endtask

  task automatic chk_irq();
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'((m_raw & m_en) != 0), "irq");
  endtask

  // Measures the spacing of two tick pulses in clocks.
  task automatic tick_per();
    int n;
    while (tick !== 1'b1) @(posedge clk_i);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (tick !== 1'b1 && n < 600);
    chk(32'(n), 32'(m_reload + 1), "tick period");
  endtask

  // Starts one pulse, checks its length and records the completion flag.
  task automatic pulse();
    int n;
    hv_start <= 1'b1;
    @(posedge clk_i);
    hv_start <= 1'b0;
    n = 0;
    @(posedge clk_i);
    while (hv_pulse === 1'b1 && n < 2000)
    begin
      n++;
      @(posedge clk_i);
    end
    chk(32'(n), 32'(int'(PULSE) * (m_reload + 1)), "pulse length");
    m_raw = m_raw | 2;
    repeat (3) @(posedge clk_i);
  endtask

  // Holds the clock enable low and counts the cycles in which tick or irq moves or hv_pulse is high.
  task automatic freeze();
    int n;
    logic t;
    logic q;
    ce <= 1'b0;
    @(posedge clk_i);
    t = tick;
    q = irq;
    n = 0;
    repeat (120)
    begin
      @(posedge clk_i);
      if (tick !== t || irq !== q || hv_pulse !== 1'b0)
        n++;
    end
    ce <= 1'b1;
    chk(32'(n), 32'h0000_0000, "frozen outputs");
    @(posedge clk_i);
  endtask

  task automatic access_evt();
    bad_evt <= 1'b1;
    @(posedge clk_i);
    bad_evt <= 1'b0;
    m_raw = m_raw | 1;
    @(posedge clk_i);
  endtask

  initial
  begin
    logic [31:0] r;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(A_RL);
    rd(A_RAW);
    rd(A_EN);
    rd(A_MSK);
    tick_per();
    rd(12'h1F0);
    wr(12'h1F0, 32'($random(seed)));
    rd(A_RL);
    $display("test reset and map done");
    for (int i = 0; i < 3; i++)
    begin
      r = $random(seed);
      r[7:0] = 8'(i * 3);
      wr(A_RL, r);
      rd(A_RL);
      tick_per();
      pulse();
      rd(A_RAW);
      rd(A_MSK);
      chk_irq();
      wr(A_MSK, 32'h0000_0002);
      rd(A_RAW);
    end
    $display("test tick and pulse done");
    freeze();
    rd(A_RL);
    tick_per();
    $display("test clock enable done");
    access_evt();
    rd(A_RAW);
    rd(A_MSK);
    chk_irq();
    wr(A_MSK, 32'h0000_0000);
    rd(A_RAW);
    wr(A_MSK, 32'h0000_0001);
    rd(A_RAW);
    wr(A_EN, 32'h0000_0003);
    rd(A_EN);
    access_evt();
    rd(A_MSK);
    chk_irq();
    wr(A_MSK, 32'h0000_0000);
    rd(A_MSK);
    pulse();
    rd(A_MSK);
    wr(A_MSK, 32'h0000_0001);
    rd(A_RAW);
    chk_irq();
    wr(A_MSK, 32'h0000_0002);
    rd(A_RAW);
    chk_irq();
    $display("test events done");
    finish_test();
  end
endmodule
